/* File: logic/sdram_ctl_end.sv */
// controller end: apb registers, command sequencer, refresh, deep power-down
//
// Functional notes
// - refresh at most every 7.8125 us
// - deep power-down loses array contents
// - deep power-down entry: banks idle, cke low
// - deep power-down exits when cke rises
// - activate a row before column commands
// - column command waits activate-to-column time
// - new row needs precharge; row cycle spacing
// - activates to different banks row-to-row apart
// - auto precharge closes row after burst
// - first data after cas latency, then per clock
// - data pins float after burst ends
// - new read cl-1 before last element
// - read accepted every cycle, any bank
// - write after read: leave idle cycle
// - mask high two clocks before write
// - interrupting write floats data pins
// - mask low at write command
// - precharge cl-1 before last element
// - nothing to bank until precharge time
// - burst terminate cl-1 before last element
// - explicit precharge equals auto precharge
// - address bit selects auto precharge
//
// Decided for this implementation: the APB register port and the address map.
`default_nettype none
module sdram_ctl_end (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    sdram_if.ctl LINK
);
    import sdram_pkg::*;
    typedef enum logic [2:0] {
        S_IDLE, S_RCD, S_RBURST, S_CLOSE, S_WAIT, S_DPD, S_XPRE, S_XREF
    } state_t;
    localparam int LAST = CAS_LAT + BURST_LEN - 1;
    localparam int REF_W = $clog2(REFI_CYC + 1);
    localparam int AP = AUTO_PRECHARGE_ADDRESS_BIT;
    state_t st_q, st_d, ret_q, ret_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] bc_q, bc_d;
    logic [REF_W-1:0] ref_q, ref_d;
    logic [1:0] xref_q, xref_d;
    logic refdue_q, refdue_d, dpdreq_q, dpdreq_d, apm_q, apm_d;
    logic pend_q, pend_d, wr_q, wr_d;
    logic [BA_W-1:0] ba_q, ba_d, bao_q, bao_d;
    logic [ADDR_W-1:0] row_q, row_d, addr_q, addr_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [DQ_W-1:0] wd_q, wd_d, dqo_q, dqo_d;
    logic [DQ_W-1:0] rdat_q [BURST_LEN];
    logic [DQ_W-1:0] rdat_d [BURST_LEN];
    logic cke_q, cke_d, dqm_q, dqm_d, dqoe_q, dqoe_d;
    logic [3:0] cmd_q, cmd_d;
    logic [BANKS-1:0] open_q, open_d;
    logic [2:0] trc_q [BANKS];
    logic [2:0] trc_d [BANKS];
    logic [2:0] trrd_q, trrd_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, slverr_q, slverr_d;
    logic act, setup, wen, busy;
    logic [1:0] ridx;

    ////////////////////////////////////////////////////////////////////////
    // per-bank row cycle timers
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_comb begin
            if (act && ba_q == BA_W'(b)) begin
                trc_d[b] = 3'(RC_CYC - 1);
            end else if (trc_q[b] != '0) begin
                trc_d[b] = trc_q[b] - 1'b1;
            end else begin
                trc_d[b] = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        setup = PSEL && !PENABLE;
        wen = PSEL && PENABLE && PWRITE && pready_q;
        busy = pend_q || st_q != S_IDLE;
        ridx = 2'(bc_q - 4'(CAS_LAT));
        act = 1'b0;
        st_d = st_q;
        ret_d = ret_q;
        cnt_d = cnt_q;
        bc_d = bc_q + 1'b1;
        ref_d = ref_q;
        xref_d = xref_q;
        refdue_d = refdue_q;
        dpdreq_d = dpdreq_q;
        apm_d = apm_q;
        pend_d = pend_q;
        wr_d = wr_q;
        ba_d = ba_q;
        row_d = row_q;
        col_d = col_q;
        wd_d = wd_q;
        rdat_d = rdat_q;
        cke_d = cke_q;
        dqm_d = dqm_q;
        dqoe_d = 1'b0;
        dqo_d = dqo_q;
        cmd_d = CMD_NOP;
        bao_d = bao_q;
        addr_d = addr_q;
        open_d = open_q;
        trrd_d = trrd_q != '0 ? trrd_q - 1'b1 : '0;
        // apb slave: zero wait states
        pready_d = setup;
        slverr_d = setup && !(PADDR inside {REG_CTRL, REG_CMD, REG_WDATA,
            REG_RD01, REG_RD23, REG_STAT});
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = '0;
            case (PADDR)
                REG_CTRL: begin
                    prdata_d[CTRL_DPD] = dpdreq_q;
                    prdata_d[CTRL_AP] = apm_q;
                end
                REG_WDATA: prdata_d[DQ_W-1:0] = wd_q;
                REG_RD01: prdata_d = {rdat_q[1], rdat_q[0]};
                REG_RD23: prdata_d = {rdat_q[3], rdat_q[2]};
                REG_STAT: begin
                    prdata_d[STAT_BUSY] = busy;
                    prdata_d[STAT_DPD] = st_q == S_DPD;
                end
                default: ;
            endcase
        end
        if (wen) begin
            case (PADDR)
                REG_CTRL: begin
                    dpdreq_d = PWDATA[CTRL_DPD];
                    apm_d = PWDATA[CTRL_AP];
                end
                REG_CMD: begin
                    if (!busy) begin
                        pend_d = 1'b1;
                        col_d = PWDATA[CMD_COL_LSB +: COL_W];
                        ba_d = PWDATA[CMD_BA_LSB +: BA_W];
                        row_d = PWDATA[CMD_ROW_LSB +: ADDR_W];
                        wr_d = PWDATA[CMD_WR_BIT];
                    end
                end
                REG_WDATA: wd_d = PWDATA[DQ_W-1:0];
                default: ;
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        unique case (st_q)
            S_IDLE: begin
                if (refdue_q) begin
                    cmd_d = CMD_REF;
                    refdue_d = 1'b0;
                    cnt_d = CNT_W'(RC_CYC - 1);
                    ret_d = S_IDLE;
                    st_d = S_WAIT;
                end else if (dpdreq_q && open_q == '0) begin
                    cke_d = 1'b0;
                    cmd_d = CMD_DPD;
                    st_d = S_DPD;
                end else if (pend_q && trc_q[ba_q] == '0 && trrd_q == '0) begin
                    cmd_d = CMD_ACT;
                    bao_d = ba_q;
                    addr_d = row_q;
                    act = 1'b1;
                    open_d[ba_q] = 1'b1;
                    trrd_d = 3'(RRD_CYC - 1);
                    dqm_d = wr_q;
                    cnt_d = wr_q ? CNT_W'(WG_CYC - 1) : CNT_W'(RCD_CYC - 1);
                    st_d = S_RCD;
                end
            end
            S_RCD: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    pend_d = 1'b0;
                    bao_d = ba_q;
                    addr_d = ADDR_W'(col_q);
                    addr_d[AP] = apm_q;
                    if (wr_q) begin
                        // no read in flight, bus already turned round
                        cmd_d = CMD_WR;
                        dqm_d = 1'b0;
                        dqo_d = wd_q;
                        dqoe_d = 1'b1;
                        st_d = S_CLOSE;
                    end else begin
                        cmd_d = CMD_RD;
                        bc_d = '0;
                        st_d = S_RBURST;
                    end
                end
            end
            S_RBURST: begin
                // element i stands on the pins while bc_q is cl + i
                if (bc_q >= 4'(CAS_LAT)) begin
                    rdat_d[ridx] = LINK.dq_mem;
                end
                if (bc_q == 4'(BURST_LEN - 1) && !apm_q) begin
                    cmd_d = CMD_PRE;
                    bao_d = ba_q;
                    addr_d = '0;
                    open_d[ba_q] = 1'b0;
                end
                if (bc_q == 4'(LAST)) begin
                    open_d[ba_q] = 1'b0;
                    cnt_d = CNT_W'(RP_CYC - 1);
                    ret_d = S_IDLE;
                    st_d = S_WAIT;
                end
            end
            S_CLOSE: begin
                if (!apm_q) begin
                    cmd_d = CMD_PRE;
                    bao_d = ba_q;
                    addr_d = '0;
                end
                open_d[ba_q] = 1'b0;
                cnt_d = CNT_W'(RP_CYC - 1);
                ret_d = S_IDLE;
                st_d = S_WAIT;
            end
            S_WAIT: begin
                if (cnt_q == '0) begin
                    st_d = ret_q;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            S_DPD: begin
                if (!dpdreq_q) begin
                    cke_d = 1'b1;
                    cnt_d = CNT_W'(DPDX_CYC - 1);
                    ret_d = S_XPRE;
                    st_d = S_WAIT;
                end
            end
            S_XPRE: begin
                cmd_d = CMD_PRE;
                addr_d = '0;
                addr_d[AP] = 1'b1;
                xref_d = '0;
                cnt_d = CNT_W'(RP_CYC - 1);
                ret_d = S_XREF;
                st_d = S_WAIT;
            end
            S_XREF: begin
                cmd_d = CMD_REF;
                xref_d = xref_q + 1'b1;
                cnt_d = CNT_W'(RC_CYC - 1);
                ret_d = xref_q == 2'(XREF_NUM - 1) ? S_IDLE : S_XREF;
                st_d = S_WAIT;
            end
        endcase
        // refresh timer last so a new due flag beats its clear
        if (st_q == S_DPD) begin
            ref_d = '0;
            refdue_d = 1'b0;
        end else if (ref_q == REF_W'(REFI_CYC - 1)) begin
            ref_d = '0;
            refdue_d = 1'b1;
        end else begin
            ref_d = ref_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            st_q <= S_IDLE;
            ret_q <= S_IDLE;
            cnt_q <= '0;
            bc_q <= '0;
            ref_q <= '0;
            xref_q <= '0;
            refdue_q <= 1'b0;
            dpdreq_q <= 1'b0;
            apm_q <= 1'b0;
            pend_q <= 1'b0;
            wr_q <= 1'b0;
            ba_q <= '0;
            row_q <= '0;
            col_q <= '0;
            wd_q <= '0;
            rdat_q <= '{default: '0};
            cke_q <= CKE_RST;
            dqm_q <= DQM_RST;
            dqoe_q <= 1'b0;
            dqo_q <= '0;
            cmd_q <= CMD_NOP;
            bao_q <= '0;
            addr_q <= '0;
            open_q <= '0;
            trc_q <= '{default: '0};
            trrd_q <= '0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
        end else if (CLK_EN) begin
            st_q <= st_d;
            ret_q <= ret_d;
            cnt_q <= cnt_d;
            bc_q <= bc_d;
            ref_q <= ref_d;
            xref_q <= xref_d;
            refdue_q <= refdue_d;
            dpdreq_q <= dpdreq_d;
            apm_q <= apm_d;
            pend_q <= pend_d;
            wr_q <= wr_d;
            ba_q <= ba_d;
            row_q <= row_d;
            col_q <= col_d;
            wd_q <= wd_d;
            rdat_q <= rdat_d;
            cke_q <= cke_d;
            dqm_q <= dqm_d;
            dqoe_q <= dqoe_d;
            dqo_q <= dqo_d;
            cmd_q <= cmd_d;
            bao_q <= bao_d;
            addr_q <= addr_d;
            open_q <= open_d;
            trc_q <= trc_d;
            trrd_q <= trrd_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            slverr_q <= slverr_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = slverr_q;
    assign LINK.cke = cke_q;
    assign LINK.cs_n = cmd_q[3];
    assign LINK.ras_n = cmd_q[2];
    assign LINK.cas_n = cmd_q[1];
    assign LINK.we_n = cmd_q[0];
    assign LINK.ba = bao_q;
    assign LINK.addr = addr_q;
    assign LINK.dqm = dqm_q;
    assign LINK.dq_ctl = dqo_q;
    assign LINK.dq_ctl_oe = dqoe_q;
endmodule
`default_nettype wire

/* File: logic/sdram_pkg.sv */
// shared constants for the sdram controller end and memory end
`default_nettype none
package sdram_pkg;
    localparam int CLK_MHZ = 25;
    localparam int CAS_LAT = 3;
    localparam int BURST_LEN = 4;
    localparam int BANKS = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int DQ_W = 16;
    localparam int COL_W = 4;
    localparam int AUTO_PRECHARGE_ADDRESS_BIT = 10;
    localparam int CNT_W = 12;
    localparam int DQM_LAT = 2;
    localparam int XREF_NUM = 2;
    ////////////////////////////////////////////////////////////////////////
    localparam int T_RCD_NS = 20;
    localparam int T_RP_NS = 20;
    localparam int T_RC_NS = 70;
    localparam int T_RRD_NS = 15;
    localparam real T_REFI_US = 7.8125;
    localparam int T_DPDX_US = 100;
    localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
    localparam int RRD_CYC = (T_RRD_NS * CLK_MHZ + 999) / 1000;
    localparam int REFI_CYC = int'($floor(T_REFI_US * CLK_MHZ));
    localparam int DPDX_CYC = T_DPDX_US * CLK_MHZ;
    localparam int WG_CYC = RCD_CYC > DQM_LAT ? RCD_CYC : DQM_LAT;
    ////////////////////////////////////////////////////////////////////////
    // command code {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_DPD = 4'h6;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RD01 = 8'h0c;
    localparam logic [7:0] REG_RD23 = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam int CTRL_DPD = 0;
    localparam int CTRL_AP = 1;
    localparam int CMD_COL_LSB = 0;
    localparam int CMD_BA_LSB = 4;
    localparam int CMD_ROW_LSB = 6;
    localparam int CMD_WR_BIT = 19;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DPD = 1;
    localparam logic CKE_RST = 1'b1;
    localparam logic DQM_RST = 1'b0;
endpackage
`default_nettype wire

/* File: logic/sdram_if.sv */
// command, address, mask and data lines between controller and memory
`default_nettype none
interface sdram_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic dqm;
    logic [15:0] dq_ctl;
    logic dq_ctl_oe;
    logic [15:0] dq_mem;
    logic dq_mem_oe;
    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl,
        output dq_ctl_oe,
        input dq_mem, dq_mem_oe
    );
    modport mem (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl,
        input dq_ctl_oe,
        output dq_mem, dq_mem_oe
    );
endinterface
`default_nettype wire

/* File: logic/sdram_mem_end.sv */
// memory end: bank state, read burst pipeline, masking, deep power-down
`default_nettype none
module sdram_mem_end (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    sdram_if.mem LINK,
    output logic IN_DPD,
    output logic [sdram_pkg::BANKS-1:0] BANK_OPEN
);
    import sdram_pkg::*;
    localparam int PD = CAS_LAT - 2;
    localparam int MW = BA_W + COL_W;
    localparam int AP = AUTO_PRECHARGE_ADDRESS_BIT;
    logic [DQ_W-1:0] mem_q [2**MW];
    logic [3:0] cmd;
    logic exec, rd_busy, bad_wr, we, wipe;
    logic [MW-1:0] widx;
    logic dpd_q, dpd_d, ap_q, ap_d, dqm_q, oe_q, oe_d;
    logic [BANKS-1:0] open_q, open_d;
    logic [BA_W-1:0] bank_q, bank_d;
    logic [COL_W-1:0] col_q, col_d;
    logic [2:0] left_q, left_d;
    logic [PD-1:0] pv_q, pv_d;
    logic [DQ_W-1:0] pd_q [PD];
    logic [DQ_W-1:0] pd_d [PD];
    logic [DQ_W-1:0] dq_q, dq_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        cmd = {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n};
        exec = LINK.cke && !dpd_q;
        rd_busy = left_q != '0 || pv_q != '0 || oe_q;
        bad_wr = rd_busy && !dqm_q;
        widx = {LINK.ba, LINK.addr[COL_W-1:0]};
        we = 1'b0;
        wipe = 1'b0;
        dpd_d = dpd_q;
        open_d = open_q;
        bank_d = bank_q;
        ap_d = ap_q;
        col_d = col_q;
        left_d = left_q;
        // fetch one element per cycle, delivered cas latency later
        pv_d[0] = left_q != '0;
        pd_d[0] = mem_q[{bank_q, col_q}];
        for (int i = 1; i < PD; i++) begin
            pv_d[i] = pv_q[i-1];
            pd_d[i] = pd_q[i-1];
        end
        oe_d = pv_q[PD-1] && !dqm_q;
        dq_d = pd_q[PD-1];
        if (left_q != '0) begin
            col_d = col_q + 1'b1;
            left_d = left_q - 1'b1;
            if (left_q == 3'd1 && ap_q) begin
                open_d[bank_q] = 1'b0;
            end
        end
        if (exec) begin
            case (cmd)
                CMD_ACT: open_d[LINK.ba] = 1'b1;
                CMD_RD: begin
                    if (open_q[LINK.ba]) begin
                        bank_d = LINK.ba;
                        col_d = LINK.addr[COL_W-1:0];
                        left_d = 3'(BURST_LEN);
                        ap_d = LINK.addr[AP];
                    end
                end
                CMD_WR: begin
                    left_d = '0;
                    pv_d = '0;
                    oe_d = 1'b0;
                    we = open_q[LINK.ba] && !bad_wr && !LINK.dqm;
                    if (open_q[LINK.ba] && LINK.addr[AP]) begin
                        open_d[LINK.ba] = 1'b0;
                    end
                end
                CMD_BST: left_d = '0;
                CMD_PRE: begin
                    if (LINK.addr[AP]) begin
                        open_d = '0;
                    end else begin
                        open_d[LINK.ba] = 1'b0;
                    end
                    if (LINK.addr[AP] || LINK.ba == bank_q) begin
                        left_d = '0;
                    end
                end
                default: ;
            endcase
        end
        // array power removed: contents lost
        if (!LINK.cke && !dpd_q && cmd == CMD_DPD && open_q == '0) begin
            dpd_d = 1'b1;
            wipe = 1'b1;
            left_d = '0;
        end
        if (dpd_q && LINK.cke) begin
            dpd_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            dpd_q <= 1'b0;
            ap_q <= 1'b0;
            dqm_q <= 1'b0;
            oe_q <= 1'b0;
            open_q <= '0;
            bank_q <= '0;
            col_q <= '0;
            left_q <= '0;
            pv_q <= '0;
            dq_q <= '0;
            for (int i = 0; i < PD; i++) begin
                pd_q[i] <= '0;
            end
        end else if (CLK_EN) begin
            dpd_q <= dpd_d;
            ap_q <= ap_d;
            dqm_q <= LINK.dqm;
            oe_q <= oe_d;
            open_q <= open_d;
            bank_q <= bank_d;
            col_q <= col_d;
            left_q <= left_d;
            pv_q <= pv_d;
            dq_q <= dq_d;
            for (int i = 0; i < PD; i++) begin
                pd_q[i] <= pd_d[i];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (CLK_EN) begin
            if (wipe) begin
                for (int i = 0; i < 2**MW; i++) begin
                    mem_q[i] <= '0;
                end
            end else if (we) begin
                mem_q[widx] <= LINK.dq_ctl;
            end
        end
    end

    assign LINK.dq_mem = dq_q;
    assign LINK.dq_mem_oe = oe_q;
    assign IN_DPD = dpd_q;
    assign BANK_OPEN = open_q;
endmodule
`default_nettype wire

/* File: test/sdram_link_props.sv */
// link checker: command spacing, read data timing and masks
`default_nettype none
module sdram_link_props (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [12:0] addr,
    input wire logic dqm,
    input wire logic dq_ctl_oe,
    input wire logic dq_mem_oe
);
    import sdram_pkg::*;
    logic [3:0] c;
    assign c = {cs_n, ras_n, cas_n, we_n};
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////
    chk_act_before_rd: assert property (
        c == CMD_RD |-> $past(c) == CMD_ACT) else $error("read w/o act");
    chk_rd_data_win: assert property (
        c == CMD_RD |-> ##3 dq_mem_oe [*4] ##1 !dq_mem_oe)
        else $error("read data window wrong");
    chk_no_contend: assert property (
        !(dq_mem_oe && dq_ctl_oe)) else $error("both ends drive dq");
    chk_pre_after_rd: assert property (
        c == CMD_RD && !addr[AUTO_PRECHARGE_ADDRESS_BIT] |-> ##4 c == CMD_PRE)
        else $error("precharge not cl-1 before last");
    chk_auto_pre: assert property (
        c == CMD_RD && addr[AUTO_PRECHARGE_ADDRESS_BIT]
        |-> ##1 (c != CMD_PRE) [*6]) else $error("pre with auto pre");
    chk_wr_mask: assert property (
        c == CMD_WR |-> !dqm && dq_ctl_oe && $past(dqm))
        else $error("mask wrong around write");
    chk_dpd_entry: assert property (
        $fell(cke) |-> c == CMD_DPD) else $error("cke fell w/o dpd");
    chk_dpd_exit: assert property (
        $rose(cke) |-> ##1 (c == CMD_NOP) [*8]) else $error("no nop wait");
    chk_act_space: assert property (
        c == CMD_ACT |-> ##1 c != CMD_ACT) else $error("act too close");
endmodule
`default_nettype wire

/* File: test/sdram_activate_read_timing_tb.sv */
// bench: apb driver, note queue and verdict for the linked pair
`default_nettype none
module sdram_activate_read_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sdram_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] v;
    logic prdy;
    logic perr;
    logic in_dpd;
    logic [BANKS-1:0] bopen;
    logic [15:0] lfsr = 16'h001c;
    logic [15:0] d [4];
    logic [65:0] notes [$];
    logic [65:0] nt;
    int err_count = 0;
    int n_compared = 0;
    sdram_if sdram_if_i ();
    sdram_ctl_end sdram_ctl_end_i (.REF_CLK(clk), .RST_N(rst_n),
        .CLK_EN(clk_en), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .LINK(sdram_if_i.ctl));
    sdram_mem_end sdram_mem_end_i (.REF_CLK(clk), .RST_N(rst_n),
        .CLK_EN(clk_en), .LINK(sdram_if_i.mem), .IN_DPD(in_dpd),
        .BANK_OPEN(bopen));
    sdram_link_props sdram_link_props_i (.REF_CLK(clk), .RST_N(rst_n),
        .cke(sdram_if_i.cke), .cs_n(sdram_if_i.cs_n),
        .ras_n(sdram_if_i.ras_n), .cas_n(sdram_if_i.cas_n),
        .we_n(sdram_if_i.we_n), .addr(sdram_if_i.addr),
        .dqm(sdram_if_i.dqm), .dq_ctl_oe(sdram_if_i.dq_ctl_oe),
        .dq_mem_oe(sdram_if_i.dq_mem_oe));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt_rand(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string nm, logic [32:0] seen, logic [32:0] e);
        n_compared++;
        if (seen !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= wd;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 50);
        if (prdy !== 1'b1) begin
            err_count++;
            finish_test();
        end
        v = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // note the expected answer, then run the read
    task automatic rd(logic [7:0] a, logic [32:0] e, logic [32:0] m);
        notes.push_back({m, e & m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic poll(int b, logic val);
        int k;
        k = 0;
        do begin
            rd(REG_STAT, 33'h0, 33'h0);
            k++;
        end while (v[b] !== val && k < 4000);
        if (v[b] !== val) begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic op(logic w, logic [1:0] b, logic [3:0] c, logic [15:0] x);
        if (w)
            apb(1'b1, REG_WDATA, {16'h0, x});
        apb(1'b1, REG_CMD, {12'h0, w, lfsr[12:0], b, c});
        poll(STAT_BUSY, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (psel && pen && prdy === 1'b1 && !pwr) begin
            nt = notes.pop_front();
            check("prdata", {perr, prd} & nt[65:33], nt[32:0]);
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h40, 33'h1_0000_0000, 33'h1_ffff_ffff);
        rd(REG_STAT, 33'h0, 33'h3);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, REG_CTRL, 32'(m << CTRL_AP));
            for (int b = 0; b < BANKS; b++) begin
                for (int i = 0; i < 4; i++) begin
                    lfsr = nxt_rand(lfsr);
                    d[i] = lfsr;
                    op(1'b1, 2'(b), 4'(4 * b + i), d[i]);
                end
                op(1'b0, 2'(b), 4'(4 * b), 16'h0);
                rd(REG_RD01, {1'b0, d[1], d[0]}, 33'h1_ffff_ffff);
                rd(REG_RD23, {1'b0, d[3], d[2]}, 33'h1_ffff_ffff);
                check("bank_open", 33'(bopen), 33'h0);
            end
        end
        apb(1'b1, REG_CTRL, 32'h1);
        poll(STAT_DPD, 1'b1);
        check("in_dpd", 33'(in_dpd), 33'h1);
        apb(1'b1, REG_CTRL, 32'h0);
        poll(STAT_DPD, 1'b0);
        poll(STAT_BUSY, 1'b0);
        check("in_dpd", 33'(in_dpd), 33'h0);
        op(1'b0, 2'h0, 4'h0, 16'h0);
        rd(REG_RD01, 33'h0, 33'h1_ffff_ffff);
        rd(REG_RD23, 33'h0, 33'h1_ffff_ffff);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(REG_STAT, 33'h0, 33'h3);
        check("bank_open", 33'(bopen), 33'h0);
        finish_test();
    end
endmodule
`default_nettype wire
